// ---- common/wdu_pkg.sv ----
// watchdog unit package: register map, field layout, reset values, timing counts
// assumes a 50 MHz pclk and a 128 kHz watchdog oscillator arriving as a pin
// Function
// (RQ1) count cycles of the separate watchdog oscillator and act at the selected time-out
// (RQ2) time-out is selectable from the shortest to the longest setting inclusive
// (RQ3) the restart command clears the counter; software restarts before time-out
// (RQ4) interrupt mode raises the watchdog interrupt on expiry, usable for wake-up
// (RQ5) system reset mode issues a system reset on expiry
// (RQ6) reset and interrupt enables select stopped, interrupt, reset or interrupt-then-reset mode
// (RQ7) in combined mode taking the vector clears interrupt enable and time-out flag
// (RQ8) in combined mode an unserviced flag at the next time-out causes system reset
// (RQ9) the always-on fuse forces reset enable to one and interrupt enable to zero
// (RQ10) clearing reset enable or changing prescale only works through the timed sequence
// (RQ11) software opens the sequence writing change enable and reset enable both one
// (RQ12) within four cycles one write with change enable clear sets reset enable and prescale
// (RQ13) the time-out flag sets on expiry while configured for interrupt
// (RQ14) the time-out flag clears when its vector is taken or by writing one
// (RQ15) the interrupt request needs global enable, interrupt enable and the flag
// (RQ16) software should restart before changing prescale to avoid an immediate time-out
// (RQ17) software should clear reset cause flag and reset enable at initialisation
// (RQ18) prescale codes zero to nine select 2048 to 1048576 cycles; above nine reserved
// (RQ19) change enable is cleared by hardware four system clock cycles after being set
// (RQ20) reset cause flag set forces reset enable to one until the flag is cleared
// (RQ21) a watchdog reset sets the reset cause flag; writing zero or power-on clears it
// (RQ22) setting reset or interrupt enable by an ordinary write is allowed any time
package wdu_pkg;

  localparam int unsigned APB_AW          = 12;
  localparam logic [11:0] CSR_OFFSET      = 12'h000;
  localparam logic [11:0] CAUSE_OFFSET    = 12'h004;
  localparam logic [11:0] CMD_OFFSET      = 12'h008;

  // control/status field positions
  localparam int unsigned CSR_FLAG_BIT    = 7;
  localparam int unsigned CSR_IE_BIT      = 6;
  localparam int unsigned CSR_P3_BIT      = 5;
  localparam int unsigned CSR_CE_BIT      = 4;
  localparam int unsigned CSR_SRE_BIT     = 3;
  // reset cause register: watchdog cause flag
  localparam int unsigned CAUSE_WD_BIT    = 3;
  // command register bits
  localparam int unsigned CMD_RESTART_BIT = 0;

  localparam logic [3:0]  PRESCALE_RESET  = 4'h0;
  localparam logic [3:0]  PRESCALE_MAX    = 4'h9;
  localparam int unsigned BASE_CYCLES     = 2048;
  localparam int unsigned CNT_W           = 20;

  localparam int unsigned PCLK_HZ         = 50000000;
  localparam int unsigned OSC_HZ          = 128000;
  localparam int unsigned CE_WINDOW_CYC   = 4;
  localparam int unsigned CE_CNT_W        = 3;

  typedef struct packed {
    logic       timeout_flag;
    logic       timeout_irq_enable;
    logic       prescale_bit3;
    logic       change_enable;
    logic       system_reset_enable;
    logic [2:0] prescale_low;
  } wdu_csr_t;

  typedef enum logic [1:0] {
    WDU_STOPPED = 2'b00,
    WDU_IRQ     = 2'b01,
    WDU_RESET   = 2'b10,
    WDU_IRQ_RST = 2'b11
  } wdu_mode_t;

endpackage

// ---- hw/wdu_counter.sv ----
// watchdog oscillator-cycle counter with prescale-selected time-out
// assumes osc_tick is a one-pclk pulse per oscillator cycle, already synchronised
`timescale 1ns/1ps
module wdu_counter
  import wdu_pkg::*;
#(
  parameter int unsigned W = CNT_W
) (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       osc_tick,
  input  wire logic       restart,
  input  wire logic       run,
  input  wire logic [3:0] prescale_select,
  output logic            expire_q
);

  logic [W-1:0] count_q;

  // reserved codes behave as the longest period
  function automatic logic [W-1:0] limit_of(input logic [3:0] sel);
    logic [3:0] s;
    s = (sel > PRESCALE_MAX) ? PRESCALE_MAX : sel;
    limit_of = W'((BASE_CYCLES << s) - 1);  // [RQ18] [RQ2]
  endfunction

  logic at_limit;
  assign at_limit = (count_q >= limit_of(prescale_select));  // shorter period may expire at once [RQ16]

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_q <= '0;
    end else if (restart || !run) begin
      count_q <= '0;  // [RQ3]
    end else if (osc_tick) begin
      count_q <= at_limit ? '0 : count_q + W'(1);  // [RQ1]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      expire_q <= 1'b0;
    end else begin
      expire_q <= run && !restart && osc_tick && at_limit;  // [RQ1]
    end
  end

endmodule // wdu_counter

// ---- hw/wdu_top.sv ----
// watchdog unit: APB register slave, timed-change protection, mode logic
// assumes a 50 MHz pclk, the watchdog oscillator on a pin, cpu side signals on pclk
`timescale 1ns/1ps
module wdu_top
  import wdu_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        osc_pin,
  input  wire logic        always_on_fuse,
  input  wire logic        global_irq_enable,
  input  wire logic        vector_ack,
  output logic             watchdog_irq,
  output logic             system_reset
);

  // pin synchronisers
  logic [1:0] osc_sync_q;
  logic       osc_prev_q;
  logic [1:0] fuse_sync_q;
  logic       osc_tick;
  logic       fuse_on;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_sync_q <= 2'b00;
      osc_prev_q <= 1'b0;
    end else begin
      osc_sync_q <= {osc_sync_q[0], osc_pin};
      osc_prev_q <= osc_sync_q[1];
    end
  end

  // fuse is static; the sync only keeps metastability out of the mode logic
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fuse_sync_q <= 2'b00;
    end else begin
      fuse_sync_q <= {fuse_sync_q[0], always_on_fuse};
    end
  end

  assign osc_tick = osc_sync_q[1] && !osc_prev_q;
  assign fuse_on  = fuse_sync_q[1];

  // register state
  logic            flag_q;
  logic            ie_q;
  logic            sre_q;
  logic            ce_q;
  logic [3:0]      prescale_q;
  logic [CE_CNT_W-1:0] ce_cnt_q;
  logic            cause_q;
  logic            ready_q;
  logic [31:0]     rdata_q;
  logic            slverr_q;
  logic            irq_q;
  logic            sysrst_q;

  // apb decode
  logic       access;
  logic       wr_commit;
  logic       csr_sel;
  logic       cause_sel;
  logic       cmd_sel;
  logic       mapped;
  logic       csr_wr;
  logic       cause_wr;
  logic       restart;
  wdu_csr_t   wr_csr;
  wdu_csr_t   rd_csr;

  // registers sit on aligned words; every other address is refused
  function automatic logic hit(input logic [11:0] addr, input logic [11:0] offset);
    hit = (addr == offset);
  endfunction

  assign access    = psel && penable;
  assign wr_commit = access && pwrite && ready_q;
  assign csr_sel   = hit(paddr, CSR_OFFSET);
  assign cause_sel = hit(paddr, CAUSE_OFFSET);
  assign cmd_sel   = hit(paddr, CMD_OFFSET);
  assign mapped    = csr_sel || cause_sel || cmd_sel;
  assign csr_wr    = wr_commit && csr_sel;
  assign cause_wr  = wr_commit && cause_sel;
  assign restart   = wr_commit && cmd_sel && pwdata[CMD_RESTART_BIT];  // [RQ3]
  assign wr_csr    = wdu_csr_t'(pwdata[7:0]);

  assign rd_csr = '{timeout_flag:        flag_q,
                    timeout_irq_enable:  ie_q,
                    prescale_bit3:       prescale_q[3],
                    change_enable:       ce_q,
                    system_reset_enable: sre_q,
                    prescale_low:        prescale_q[2:0]};

  // mode and expiry decisions
  wdu_mode_t mode;
  logic      expire;
  logic      do_reset;
  logic      set_flag;
  logic      ack_combined;
  logic      open_seq;
  logic      timed_wr;

  always_comb begin
    if (fuse_on) begin
      mode = WDU_RESET;  // [RQ9]
    end else begin
      mode = wdu_mode_t'({sre_q, ie_q});  // [RQ6]
    end
  end

  always_comb begin
    do_reset = 1'b0;
    set_flag = 1'b0;
    case (mode)
      WDU_STOPPED: begin
        do_reset = 1'b0;
      end
      WDU_IRQ: begin
        set_flag = expire;  // [RQ4] [RQ13]
      end
      WDU_RESET: begin
        do_reset = expire;  // [RQ5]
      end
      WDU_IRQ_RST: begin
        do_reset = expire && flag_q;   // unserviced from the previous time-out [RQ8]
        set_flag = expire && !flag_q;  // [RQ13]
      end
      default: begin
        do_reset = expire;
      end
    endcase
  end

  // the vector only disarms the interrupt in combined mode; plain interrupt mode keeps it
  assign ack_combined = vector_ack && (mode == WDU_IRQ_RST);  // [RQ7]
  assign open_seq     = csr_wr && wr_csr.change_enable && wr_csr.system_reset_enable;  // [RQ11]
  // the accepting write of the timed sequence
  assign timed_wr     = csr_wr && ce_q && !wr_csr.change_enable;  // [RQ12]

  wdu_counter #(
    .W (CNT_W)
  ) u_counter (
    .pclk            (pclk),
    .presetn         (presetn),
    .osc_tick        (osc_tick),
    .restart         (restart),
    .run             (mode != WDU_STOPPED),
    .prescale_select (prescale_q),
    .expire_q        (expire)
  );

  // apb answer: one wait state, pready a one-cycle pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ready_q <= 1'b0;
    end else begin
      ready_q <= access && !ready_q;
    end
  end

  // error rides with pready so a master never hangs on an unmapped word
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slverr_q <= 1'b0;
    end else begin
      slverr_q <= access && !ready_q && !mapped;
    end
  end

  // read data captured in the wait cycle, standing through the pready cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_q <= 32'h0000_0000;
    end else if (access && !ready_q && !pwrite) begin
      if (csr_sel) begin
        rdata_q <= {24'h00_0000, rd_csr};
      end else if (cause_sel) begin
        rdata_q <= 32'(cause_q) << CAUSE_WD_BIT;
      end else begin
        rdata_q <= 32'h0000_0000;
      end
    end
  end

  // change enable window: closes four cycles after opening or on the next csr write that does not reopen it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ce_q     <= 1'b0;
      ce_cnt_q <= '0;
    end else if (sysrst_q) begin
      ce_q     <= 1'b0;
      ce_cnt_q <= '0;
    end else if (open_seq) begin
      ce_q     <= 1'b1;
      ce_cnt_q <= CE_CNT_W'(CE_WINDOW_CYC - 1);
    end else if (ce_q && csr_wr) begin
      ce_q     <= 1'b0;  // [RQ12]
      ce_cnt_q <= '0;
    end else if (ce_q) begin
      ce_cnt_q <= ce_cnt_q - CE_CNT_W'(1);
      if (ce_cnt_q == '0) begin
        ce_q <= 1'b0;  // [RQ19]
      end
    end
  end

  // reset enable: forcing only pins this bit, the timed write still moves prescale
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sre_q <= 1'b0;
    end else if (fuse_on || cause_q || do_reset) begin
      sre_q <= 1'b1;  // [RQ9] [RQ20]
    end else if (timed_wr) begin
      sre_q <= wr_csr.system_reset_enable;  // [RQ10] [RQ12]
    end else if (csr_wr) begin
      sre_q <= sre_q || wr_csr.system_reset_enable;  // clear refused outside window [RQ10] [RQ22]
    end
  end

  // prescale: only the timed write or a watchdog reset moves it, so a stray store cannot shorten the period
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prescale_q <= PRESCALE_RESET;
    end else if (do_reset) begin
      prescale_q <= PRESCALE_RESET;
    end else if (timed_wr) begin
      prescale_q <= {wr_csr.prescale_bit3, wr_csr.prescale_low};  // [RQ10] [RQ12]
    end
  end

  // interrupt enable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ie_q <= 1'b0;
    end else if (fuse_on || do_reset) begin
      ie_q <= 1'b0;  // [RQ9]
    end else if (csr_wr) begin
      ie_q <= wr_csr.timeout_irq_enable;  // [RQ22]
    end else if (ack_combined) begin
      ie_q <= 1'b0;  // back to plain reset mode [RQ7]
    end
  end

  // time-out flag: a new expiry wins over any clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_q <= 1'b0;
    end else if (set_flag) begin
      flag_q <= 1'b1;  // [RQ13]
    end else if (do_reset) begin
      flag_q <= 1'b0;
    end else if (vector_ack || (csr_wr && wr_csr.timeout_flag)) begin
      flag_q <= 1'b0;  // [RQ14] [RQ7]
    end
  end

  // reset cause flag: survives the system reset it reports, only presetn or a write of zero clears it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cause_q <= 1'b0;
    end else if (do_reset) begin
      cause_q <= 1'b1;  // [RQ21]
    end else if (cause_wr && !pwdata[CAUSE_WD_BIT]) begin
      cause_q <= 1'b0;  // [RQ21]
    end
  end

  // interrupt request drops in the cycle after the vector is taken
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= global_irq_enable && ie_q && flag_q && !fuse_on && !vector_ack;  // [RQ15] [RQ4]
    end
  end

  // a single-cycle pulse; the device reset logic stretches it as it needs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sysrst_q <= 1'b0;
    end else begin
      sysrst_q <= do_reset;  // [RQ5] [RQ8]
    end
  end

  assign prdata       = rdata_q;
  assign pready       = ready_q;
  assign pslverr      = slverr_q;
  assign watchdog_irq = irq_q;
  assign system_reset = sysrst_q;

endmodule // wdu_top

// ---- test/wdu_properties.sv ----
// port checker for the watchdog unit: apb answer, error, reset pulse, irq gating
// assumes every watched signal belongs to the pclk domain
`timescale 1ns/1ps
module wdu_properties
  import wdu_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        osc_pin,
  input wire logic        always_on_fuse,
  input wire logic        global_irq_enable,
  input wire logic        vector_ack,
  input wire logic        watchdog_irq,
  input wire logic        system_reset
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic mapped;
  assign mapped = paddr inside {CSR_OFFSET, CAUSE_OFFSET, CMD_OFFSET};
  sequence setup_s;
    psel && !penable;
  endsequence
  sequence access_s;
    setup_s ##1 psel && penable;
  endsequence
  apb_wait_a: assert property (access_s |=> pready)
    else $error("no answer after one wait state");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("pready held beyond one cycle");
  err_unmapped_a: assert property (pready && !mapped |-> pslverr)
    else $error("unmapped access without error");
  err_mapped_a: assert property (pready && mapped |-> !pslverr)
    else $error("mapped access flagged as error");
  err_zero_a: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
    else $error("unmapped read returned data");
  rst_pulse_a: assert property (system_reset |=> !system_reset)
    else $error("system reset longer than one cycle");
  irq_gate_a: assert property (!global_irq_enable |=> !watchdog_irq)
    else $error("interrupt raised with global enable low");
  irq_ack_a: assert property (vector_ack |-> ##2 !watchdog_irq)
    else $error("interrupt stays after vector taken");
endmodule // wdu_properties

bind wdu_top wdu_properties u_props (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .osc_pin(osc_pin), .always_on_fuse(always_on_fuse), .global_irq_enable(global_irq_enable),
  .vector_ack(vector_ack), .watchdog_irq(watchdog_irq), .system_reset(system_reset));

// ---- test/watchdog_timer_unit_bench.sv ----
// self-checking bench for wdu_top: registers, timed sequence, modes, fuse
// assumes a 50 MHz pclk; osc_pin runs at 8 pclk per cycle to keep time-outs short
`timescale 1ns/1ps
module watchdog_timer_unit_bench;
  import wdu_pkg::*;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, osc_pin = 0;
  logic        always_on_fuse = 0, global_irq_enable = 0, vector_ack = 0, held = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rdat;
  logic        pready, pslverr, watchdog_irq, system_reset, rerr;
  logic [1:0]  osc_div = '0;
  int          fail_count = 0, total_checks = 0, n;

  always #10 pclk = ~pclk;
  always @(posedge pclk) begin
    osc_div <= osc_div + 2'h1;
    if (osc_div == 2'h3) osc_pin <= ~osc_pin;
  end

  wdu_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .osc_pin(osc_pin), .always_on_fuse(always_on_fuse), .global_irq_enable(global_irq_enable),
    .vector_ack(vector_ack), .watchdog_irq(watchdog_irq), .system_reset(system_reset));

  task automatic final_report();
    $display("checks %0d errors %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // keep leaves psel up so the next setup follows at once (timed window is short)
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic keep);
    int k;
    if (!held) begin
      @(posedge pclk);
      psel <= 1'b1;
    end
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) begin
      fail_count++;
      final_report();
    end
    rdat = prdata;
    rerr = pslverr;
    penable <= 1'b0;
    if (!keep) psel <= 1'b0;
    held = keep;
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic keep = 1'b0);
    apb(1'b1, a, {24'h0, d}, keep);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0, 1'b0);
    chk(rdat, e);
  endtask

  task automatic wait_evt(input logic rst_evt);
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while ((rst_evt ? system_reset : watchdog_irq) !== 1'b1 && n < 17000);
    if (n >= 17000) begin
      fail_count++;
      final_report();
    end
  endtask

  task automatic t_reset();
    rd(CSR_OFFSET, 32'h0);
    rd(CAUSE_OFFSET, 32'h0);
    wr(12'h00C, 8'hFF);
    chk(rerr, 32'h1);
    rd(12'h00C, 32'h0);
    chk(rerr, 32'h1);
  endtask

  task automatic t_timed();
    wr(CSR_OFFSET, 8'h08);
    rd(CSR_OFFSET, 32'h08);
    wr(CSR_OFFSET, 8'h01);
    rd(CSR_OFFSET, 32'h08);
    wr(CMD_OFFSET, 8'h01);
    wr(CSR_OFFSET, 8'h18, 1'b1);
    wr(CSR_OFFSET, 8'h01);
    rd(CSR_OFFSET, 32'h01);
    wr(CSR_OFFSET, 8'h19);
    repeat (6) @(posedge pclk);
    rd(CSR_OFFSET, 32'h09);
    wr(CSR_OFFSET, 8'h00);
    rd(CSR_OFFSET, 32'h09);
    wr(CSR_OFFSET, 8'h19, 1'b1);
    wr(CSR_OFFSET, 8'h00);
    rd(CSR_OFFSET, 32'h00);
  endtask

  task automatic t_irq();
    wr(CMD_OFFSET, 8'h01);
    wr(CSR_OFFSET, 8'h40);
    global_irq_enable <= 1'b1;
    repeat (10000) @(posedge pclk);
    chk(watchdog_irq, 32'h0);
    wr(CMD_OFFSET, 8'h01);
    wait_evt(1'b0);
    chk(32'(n > 16370 && n < 16420), 32'h1);
    rd(CSR_OFFSET, 32'hC0);
    global_irq_enable <= 1'b0;
    wr(CSR_OFFSET, 8'hC0);
    rd(CSR_OFFSET, 32'h40);
    wr(CSR_OFFSET, 8'h00);
    rd(CSR_OFFSET, 32'h00);
  endtask

  task automatic t_combined();
    global_irq_enable <= 1'b1;
    wr(CMD_OFFSET, 8'h01);
    wr(CSR_OFFSET, 8'h48);
    wait_evt(1'b0);
    rd(CSR_OFFSET, 32'hC8);
    wait_evt(1'b1);
    rd(CAUSE_OFFSET, 32'h08);
    wr(CSR_OFFSET, 8'h18, 1'b1);
    wr(CSR_OFFSET, 8'h01);
    rd(CSR_OFFSET, 32'h09);
    wr(CSR_OFFSET, 8'h18, 1'b1);
    wr(CSR_OFFSET, 8'h00);
    rd(CSR_OFFSET, 32'h08);
  endtask

  task automatic t_ack();
    wr(CSR_OFFSET, 8'h48);
    wait_evt(1'b0);
    vector_ack <= 1'b1;
    @(posedge pclk);
    vector_ack <= 1'b0;
    rd(CSR_OFFSET, 32'h08);
    wr(CAUSE_OFFSET, 8'h00);
    rd(CAUSE_OFFSET, 32'h00);
    wr(CSR_OFFSET, 8'h18, 1'b1);
    wr(CSR_OFFSET, 8'h00);
    rd(CSR_OFFSET, 32'h00);
  endtask

  task automatic t_fuse();
    always_on_fuse <= 1'b1;
    repeat (4) @(posedge pclk);
    wr(CSR_OFFSET, 8'h40);
    rd(CSR_OFFSET, 32'h08);
    wr(CMD_OFFSET, 8'h01);
    wait_evt(1'b1);
    chk(32'(n > 16370 && n < 16420), 32'h1);
    rd(CAUSE_OFFSET, 32'h08);
  endtask

  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_timed();
    t_irq();
    t_combined();
    t_ack();
    t_fuse();
    final_report();
  end
endmodule // watchdog_timer_unit_bench
